// ### include/dispatch_pkg.sv
// Purpose: Shared constants for the procedure call dispatcher
// Assumes: 32-bit words, byte addresses on both buses
// Notes: Register offsets are byte addresses on the slave bus
package dispatch_pkg;
	// Slave register byte offsets
	localparam logic [5:0] OFF_CMD = 6'h00;
	localparam logic [5:0] OFF_OPERAND = 6'h04;
	localparam logic [5:0] OFF_IP = 6'h08;
	localparam logic [5:0] OFF_STACK_TOP = 6'h0C;
	localparam logic [5:0] OFF_FP = 6'h10;
	localparam logic [5:0] OFF_PFP = 6'h14;
	localparam logic [5:0] OFF_TABLE = 6'h18;
	localparam logic [5:0] OFF_SSB = 6'h1C;
	localparam logic [5:0] OFF_DEPTH = 6'h20;

	// Status bits in the command register
	localparam int STAT_BUSY = 0;
	localparam int STAT_SUPER = 1;
	localparam int STAT_TRACE = 2;
	localparam int STAT_ERROR = 3;
	localparam int STAT_READY = 4;

	// Commands written to the command register, low three bits
	localparam logic [2:0] CMD_CALL = 3'h0;
	localparam logic [2:0] CMD_CALLX = 3'h1;
	localparam logic [2:0] CMD_CALLX_IPREL = 3'h2;
	localparam logic [2:0] CMD_CALLS = 3'h3;
	localparam logic [2:0] CMD_FAULT = 3'h4;
	localparam logic [2:0] CMD_RET = 3'h5;

	// Memory layout of the control block and procedure table
	localparam logic [31:0] CTRL_BASE_DEFAULT = 32'h0000_0000;
	localparam logic [31:0] CTRL_TABLE_OFF = 32'h0000_0014;
	localparam logic [31:0] TBL_SSB_OFF = 32'h0000_000C;
	localparam logic [31:0] TBL_ENTRY_OFF = 32'h0000_0030;
	localparam int TBL_BYTES = 1088;
	localparam int TBL_ENTRIES = 260;

	// Entry types and return-type codes
	localparam logic [1:0] ET_LOCAL = 2'h0;
	localparam logic [1:0] ET_SUPER = 2'h2;
	localparam logic [2:0] RT_LOCAL = 3'h0;
	localparam logic [2:0] RT_FAULT = 3'h1;
	localparam logic [1:0] RT_SUPER_HI = 2'h1;

	// Frame geometry and cache size
	localparam logic [31:0] FRAME_BYTES = 32'h0000_0040;
	localparam int CACHE_FRAMES_DEFAULT = 16;

	// Reset values of the context registers
	localparam logic [31:0] CTX_RESET = 32'h0000_0000;
endpackage

// ### rtl/procedure_call_dispatch.sv
// Purpose: Call control for local calls and system-table calls
// Assumes: Memory port answers reads with waitrequest semantics
// Notes: Leaves reset in user mode with bases fetched by the init reads
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module procedure_call_dispatch #(
	parameter logic [31:0] CTRL_BASE = dispatch_pkg::CTRL_BASE_DEFAULT,
	parameter int CACHE_FRAMES = dispatch_pkg::CACHE_FRAMES_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [31:0] mem_address,
	output logic mem_read,
	input wire logic [31:0] mem_readdata,
	input wire logic mem_waitrequest,
	output logic supervisor_mode,
	output logic trace_enable_flag
);

	typedef enum logic [2:0] {
		ST_BOOT,
		ST_INIT_TABLE,
		ST_INIT_SSB,
		ST_IDLE,
		ST_FETCH
	} state_e;

	////////////////////////////////////////////////////////////////
	// Helpers

	// Round up to the next 16-byte boundary
	function automatic logic [31:0] align16(input logic [31:0] a);
		logic [31:0] s;
		s = a + 32'h0000_000F;
		return {s[31:4], 4'h0};
	endfunction

	// Previous frame pointer word with a return type in the low bits
	function automatic logic [31:0] pfp_word(input logic [31:0] f, input logic [2:0] rt);
		return {f[31:4], 1'b0, rt};
	endfunction

	////////////////////////////////////////////////////////////////
	// Declarations

	state_e state_reg;
	logic [31:0] operand_reg;
	logic [31:0] ip_reg;
	logic [31:0] stack_top_reg;
	logic [31:0] fp_reg;
	logic [31:0] pfp_reg;
	logic [31:0] table_reg;
	logic [31:0] ssb_reg;
	logic trace_ctrl_reg;
	logic error_reg;
	logic fault_pending_reg;
	logic [7:0] depth_reg;
	logic [2:0] cmd;
	logic bus_wr;
	logic cmd_go;
	logic mem_done;
	logic [31:0] disp24;
	logic [31:0] entry_addr;
	logic [31:0] entry_target;
	logic [1:0] entry_type;
	logic idx_ok;
	logic [7:0] depth_max;

	////////////////////////////////////////////////////////////////
	// Decode

	// A write is taken only on the edge where waitrequest is low
	assign bus_wr = write && !waitrequest;
	assign cmd = writedata[2:0];
	// Commands arriving while busy are dropped, not queued
	assign cmd_go = bus_wr && (address == dispatch_pkg::OFF_CMD) && (state_reg == ST_IDLE);
	assign mem_done = mem_read && !mem_waitrequest;
	// Word displacement already in bytes, sign-extended from bit 23; bits 1:0 are not cleared
	assign disp24 = {{8{operand_reg[23]}}, operand_reg[23:0]};
	// Out-of-range procedure numbers never reach memory
	assign idx_ok = operand_reg < 32'(dispatch_pkg::TBL_ENTRIES);
	assign entry_addr = table_reg + dispatch_pkg::TBL_ENTRY_OFF + {operand_reg[29:0], 2'h0};
	assign entry_target = {mem_readdata[31:2], 2'h0};
	assign entry_type = mem_readdata[1:0];
	assign depth_max = 8'(CACHE_FRAMES);

	////////////////////////////////////////////////////////////////
	// Slave handshake: one wait cycle, then a one-cycle answer

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// Read data captured in the wait cycle, valid when waitrequest drops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			readdata <= 32'h0000_0000;
		end else if (read && waitrequest) begin
			case (address)
				dispatch_pkg::OFF_CMD: begin
					readdata <= {27'h0, state_reg != ST_BOOT && state_reg != ST_INIT_TABLE
						&& state_reg != ST_INIT_SSB, error_reg, trace_enable_flag,
						supervisor_mode, state_reg != ST_IDLE};
				end
				dispatch_pkg::OFF_OPERAND: readdata <= operand_reg;
				dispatch_pkg::OFF_IP: readdata <= ip_reg;
				dispatch_pkg::OFF_STACK_TOP: readdata <= stack_top_reg;
				dispatch_pkg::OFF_FP: readdata <= fp_reg;
				dispatch_pkg::OFF_PFP: readdata <= pfp_reg;
				dispatch_pkg::OFF_TABLE: readdata <= table_reg;
				dispatch_pkg::OFF_SSB: readdata <= ssb_reg;
				dispatch_pkg::OFF_DEPTH: readdata <= {24'h0, depth_reg};
				default: readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Operand register, free to change only while idle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			operand_reg <= dispatch_pkg::CTX_RESET;
		end else if (bus_wr && address == dispatch_pkg::OFF_OPERAND && state_reg == ST_IDLE) begin
			operand_reg <= writedata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequencer and memory read port

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_BOOT;
			mem_read <= 1'b0;
			mem_address <= 32'h0000_0000;
		end else begin
			case (state_reg)
				ST_BOOT: begin
					mem_address <= CTRL_BASE + dispatch_pkg::CTRL_TABLE_OFF;
					mem_read <= 1'b1;
					state_reg <= ST_INIT_TABLE;
				end
				ST_INIT_TABLE: begin
					if (mem_done) begin
						mem_address <= mem_readdata + dispatch_pkg::TBL_SSB_OFF;
						state_reg <= ST_INIT_SSB;
					end
				end
				ST_INIT_SSB: begin
					if (mem_done) begin
						mem_read <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (cmd_go && (cmd == dispatch_pkg::CMD_CALLS
						|| cmd == dispatch_pkg::CMD_FAULT) && idx_ok) begin
						mem_address <= entry_addr;
						mem_read <= 1'b1;
						state_reg <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (mem_done) begin
						mem_read <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					mem_read <= 1'b0;
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Cached bases: written once during init, never again until reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			table_reg <= 32'h0000_0000;
			ssb_reg <= 32'h0000_0000;
			trace_ctrl_reg <= 1'b0;
		end else if (mem_done && state_reg == ST_INIT_TABLE) begin
			table_reg <= mem_readdata;
		end else if (mem_done && state_reg == ST_INIT_SSB) begin
			ssb_reg <= {mem_readdata[31:2], 2'h0};
			trace_ctrl_reg <= mem_readdata[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Call and return context

	// Local calls finish in the command cycle; table calls after the fetch
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ip_reg <= dispatch_pkg::CTX_RESET;
			stack_top_reg <= dispatch_pkg::CTX_RESET;
			fp_reg <= dispatch_pkg::CTX_RESET;
			pfp_reg <= dispatch_pkg::CTX_RESET;
			supervisor_mode <= 1'b0;
			trace_enable_flag <= 1'b0;
			fault_pending_reg <= 1'b0;
			error_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && cmd_go) begin
			error_reg <= 1'b0;
			fault_pending_reg <= (cmd == dispatch_pkg::CMD_FAULT);
			case (cmd)
				dispatch_pkg::CMD_CALL, dispatch_pkg::CMD_CALLX,
				dispatch_pkg::CMD_CALLX_IPREL: begin
					// Same stack, same mode, only the target differs
					if (cmd == dispatch_pkg::CMD_CALL) begin
						ip_reg <= ip_reg + disp24;
					end else if (cmd == dispatch_pkg::CMD_CALLX) begin
						ip_reg <= operand_reg;
					end else begin
						ip_reg <= ip_reg + operand_reg;
					end
					fp_reg <= align16(stack_top_reg);
					stack_top_reg <= align16(stack_top_reg) + dispatch_pkg::FRAME_BYTES;
					pfp_reg <= pfp_word(fp_reg, dispatch_pkg::RT_LOCAL);
				end
				dispatch_pkg::CMD_CALLS, dispatch_pkg::CMD_FAULT: begin
					// Bad procedure number flagged without a fetch
					error_reg <= !idx_ok;
				end
				dispatch_pkg::CMD_RET: begin
					// Return action from the low bits of the saved pointer
					fp_reg <= {pfp_reg[31:4], 4'h0};
					if (pfp_reg[2:1] == dispatch_pkg::RT_SUPER_HI) begin
						supervisor_mode <= 1'b0;
						trace_enable_flag <= pfp_reg[0];
					end
				end
				default: begin
					error_reg <= 1'b1;
				end
			endcase
		end else if (state_reg == ST_IDLE && bus_wr) begin
			// Software may reposition the stack or frame between calls
			case (address)
				dispatch_pkg::OFF_IP: ip_reg <= writedata;
				dispatch_pkg::OFF_STACK_TOP: stack_top_reg <= writedata;
				dispatch_pkg::OFF_FP: fp_reg <= writedata;
				dispatch_pkg::OFF_PFP: pfp_reg <= writedata;
				default: ;
			endcase
		end else if (state_reg == ST_FETCH && mem_done) begin
			if (entry_type == dispatch_pkg::ET_LOCAL) begin
				ip_reg <= entry_target;
				fp_reg <= align16(stack_top_reg);
				stack_top_reg <= align16(stack_top_reg) + dispatch_pkg::FRAME_BYTES;
				pfp_reg <= pfp_word(fp_reg, fault_pending_reg ? dispatch_pkg::RT_FAULT
					: dispatch_pkg::RT_LOCAL);
			end else if (entry_type == dispatch_pkg::ET_SUPER) begin
				ip_reg <= entry_target;
				if (!supervisor_mode) begin
					supervisor_mode <= 1'b1;
					fp_reg <= align16(ssb_reg);
					stack_top_reg <= align16(ssb_reg) + dispatch_pkg::FRAME_BYTES;
					pfp_reg <= pfp_word(fp_reg, {dispatch_pkg::RT_SUPER_HI,
						trace_enable_flag});
					trace_enable_flag <= trace_ctrl_reg;
				end else begin
					fp_reg <= align16(stack_top_reg);
					stack_top_reg <= align16(stack_top_reg) + dispatch_pkg::FRAME_BYTES;
					pfp_reg <= pfp_word(fp_reg, fault_pending_reg ? dispatch_pkg::RT_FAULT
						: dispatch_pkg::RT_LOCAL);
				end
			end else begin
				// Reserved types leave context untouched and report it
				error_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register cache occupancy

	// Locals go to on-chip sets; the count only tracks use, no bus traffic
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			depth_reg <= 8'h00;
		end else if (state_reg == ST_IDLE && cmd_go && cmd == dispatch_pkg::CMD_RET) begin
			if (depth_reg != 8'h00) begin
				depth_reg <= depth_reg - 8'h01;
			end
		end else if ((state_reg == ST_IDLE && cmd_go && (cmd == dispatch_pkg::CMD_CALL
			|| cmd == dispatch_pkg::CMD_CALLX || cmd == dispatch_pkg::CMD_CALLX_IPREL))
			|| (state_reg == ST_FETCH && mem_done && !entry_type[0])) begin
			if (depth_reg != depth_max) begin
				depth_reg <= depth_reg + 8'h01;
			end
		end
	end

endmodule

// ### dv/dispatch_checker.sv
// Purpose: Port checks for the call dispatcher
// Assumes: Init makes two memory reads before any table fetch
// Notes: Bound to every dispatcher instance
`timescale 1ns/1ps
module dispatch_checker #(
	parameter logic [31:0] CTRL_BASE = dispatch_pkg::CTRL_BASE_DEFAULT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic [31:0] mem_address,
	input wire logic mem_read,
	input wire logic [31:0] mem_readdata,
	input wire logic mem_waitrequest,
	input wire logic supervisor_mode,
	input wire logic trace_enable_flag
);
	default clocking dclk @(posedge clk); endclocking
	default disable iff (reset);
	logic [1:0] init_reg;
	logic acc;
	logic call_acc;
	logic cmd_acc;
	logic local_cmd;
	// Init reads are counted out so only table fetches count as calls
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			init_reg <= 2'h0;
		end else if (acc && init_reg != 2'h2) begin
			init_reg <= init_reg + 2'h1;
		end
	end
	// Decoded events
	assign acc = mem_read && !mem_waitrequest;
	assign call_acc = acc && init_reg == 2'h2;
	assign cmd_acc = write && !waitrequest && address == dispatch_pkg::OFF_CMD;
	assign local_cmd = cmd_acc && writedata[2:0] <= dispatch_pkg::CMD_CALLX_IPREL;
	////////////////////////////////////////////////////////////////////////////
	property p_bus_answer; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing");
	property p_init_fetch; $fell(reset) |->
		##[0:2] (mem_read && mem_address == CTRL_BASE + dispatch_pkg::CTRL_TABLE_OFF);
	endproperty
	a_init_fetch: assert property (p_init_fetch) else $error("no base fetch");
	property p_local_mode; local_cmd |=> $stable(supervisor_mode) && $stable(trace_enable_flag);
	endproperty
	a_local_mode: assert property (p_local_mode) else $error("local call mode");
	property p_local_quiet; local_cmd && !mem_read |=> !mem_read [*2];
	endproperty
	a_local_quiet: assert property (p_local_quiet) else $error("local call bus");
	property p_sys_local; call_acc && mem_readdata[1:0] == dispatch_pkg::ET_LOCAL |=>
		$stable(supervisor_mode);
	endproperty
	a_sys_local: assert property (p_sys_local) else $error("local entry mode");
	property p_sys_super; call_acc && mem_readdata[1:0] == dispatch_pkg::ET_SUPER &&
		!supervisor_mode |=> supervisor_mode;
	endproperty
	a_sys_super: assert property (p_sys_super) else $error("no mode switch");
	property p_reserved; call_acc && mem_readdata[0] |=> $stable(supervisor_mode) &&
		$stable(trace_enable_flag);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved entry used");
	property p_rise_cause; $rose(supervisor_mode) |-> $past(call_acc);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("stray switch");
	property p_fall_cause; $fell(supervisor_mode) |->
		$past(cmd_acc && writedata[2:0] == dispatch_pkg::CMD_RET);
	endproperty
	a_fall_cause: assert property (p_fall_cause) else $error("stray user mode");
	property p_trace_tied; $changed(trace_enable_flag) |-> $changed(supervisor_mode);
	endproperty
	a_trace_tied: assert property (p_trace_tied) else $error("stray trace");
	// Main scenarios
	c_switch: cover property ($rose(supervisor_mode));
	c_return: cover property ($fell(supervisor_mode));
	c_reserved: cover property (call_acc && mem_readdata[0]);
endmodule
bind procedure_call_dispatch dispatch_checker #(.CTRL_BASE(CTRL_BASE)) dispatch_checker_i (
	.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
	.writedata(writedata), .waitrequest(waitrequest), .mem_address(mem_address),
	.mem_read(mem_read), .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest),
	.supervisor_mode(supervisor_mode), .trace_enable_flag(trace_enable_flag));

// ### dv/call_memory_model.sv
// Purpose: Memory with control block, procedure table and stack base word
// Assumes: Word reads; stall gives wait cycles per read
// Notes: Idle data is inverted so stale words never look valid
`timescale 1ns/1ps
module call_memory_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [31:0] mem_address,
	input wire logic mem_read,
	input wire logic [3:0] stall,
	output logic [31:0] mem_readdata,
	output logic mem_waitrequest
);
	logic [31:0] mem [0:511];
	logic [31:0] last_reg;
	logic [3:0] wait_reg;
	logic hit;
	// Table at 0x100; entries 2 and 3 break the type rule on purpose
	// Why: they drive the error path, legal tables never hold them
	initial begin
		mem[5] = 32'h0000_0100;
		mem[67] = 32'h0000_2005;
		mem[76] = 32'h0000_4000;
		mem[77] = 32'h0000_5002;
		mem[78] = 32'h0000_6001;
		mem[79] = 32'h0000_7003;
	end
	// Answer once the set number of wait cycles has passed
	assign hit = mem_read && wait_reg == stall;
	assign mem_waitrequest = !hit;
	assign mem_readdata = hit ? mem[mem_address[10:2]] : ~last_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_reg <= 4'h0;
			last_reg <= 32'h0;
		end else if (hit) begin
			wait_reg <= 4'h0;
			last_reg <= mem[mem_address[10:2]];
		end else if (mem_read) begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule

// ### dv/tb_procedure_call_dispatch.sv
// Purpose: Self-checking bench for the call dispatcher
// Assumes: Table at 0x100, stack base word 0x2005
// Notes: Contexts are set through registers before calls
`timescale 1ns/1ps
module tb_procedure_call_dispatch;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] address = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] stall = 4'h0;
	logic [31:0] readdata, mem_address, mem_readdata, q;
	logic waitrequest, mem_read, mem_waitrequest, supervisor_mode, trace_enable_flag;
	int bad_count = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	procedure_call_dispatch procedure_call_dispatch_i (.clk(clk), .reset(reset),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .mem_address(mem_address),
		.mem_read(mem_read), .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest),
		.supervisor_mode(supervisor_mode), .trace_enable_flag(trace_enable_flag));
	call_memory_model call_memory_model_i (.clk(clk), .reset(reset), .mem_address(mem_address),
		.mem_read(mem_read), .stall(stall), .mem_readdata(mem_readdata),
		.mem_waitrequest(mem_waitrequest));
	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_up(input int n);
		if (n >= 40) begin
			bad_count++;
			tally_and_finish;
		end
	endtask
	// One transfer, held until waitrequest is seen low; read data lands in q
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		give_up(n);
	endtask
	task automatic reg_is(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic flags(input logic [1:0] e);
		check({30'h0, supervisor_mode, trace_enable_flag}, {30'h0, e});
	endtask
	// Commands are refused while busy, so poll status until it clears
	task automatic cmd(input logic [2:0] c, input logic [31:0] op);
		int n;
		n = 0;
		bus(1'b1, dispatch_pkg::OFF_OPERAND, op);
		bus(1'b1, dispatch_pkg::OFF_CMD, {29'h0, c});
		do begin
			bus(1'b0, dispatch_pkg::OFF_CMD, 32'h0);
			n++;
		end while (q[dispatch_pkg::STAT_BUSY] !== 1'b0 && n < 40);
		give_up(n);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_init;
		int n;
		n = 0;
		do begin
			bus(1'b0, dispatch_pkg::OFF_CMD, 32'h0);
			n++;
		end while (q[dispatch_pkg::STAT_READY] !== 1'b1 && n < 40);
		give_up(n);
		reg_is(dispatch_pkg::OFF_TABLE, 32'h0000_0100);
		reg_is(dispatch_pkg::OFF_SSB, 32'h0000_2004);
		bus(1'b1, dispatch_pkg::OFF_TABLE, 32'h0000_0BAD);
		reg_is(dispatch_pkg::OFF_TABLE, 32'h0000_0100);
		reg_is(6'h24, 32'h0);
		flags(2'h0);
		$display("init test done");
	endtask
	task automatic t_local;
		bus(1'b1, dispatch_pkg::OFF_STACK_TOP, 32'h0000_1008);
		bus(1'b1, dispatch_pkg::OFF_FP, 32'h0000_1000);
		bus(1'b1, dispatch_pkg::OFF_IP, 32'h0000_0400);
		cmd(dispatch_pkg::CMD_CALL, 32'hAAFF_FFF8);
		reg_is(dispatch_pkg::OFF_IP, 32'h0000_03F8);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_1010);
		reg_is(dispatch_pkg::OFF_STACK_TOP, 32'h0000_1050);
		reg_is(dispatch_pkg::OFF_PFP, 32'h0000_1000);
		cmd(dispatch_pkg::CMD_CALLX, 32'h8000_0000);
		reg_is(dispatch_pkg::OFF_IP, 32'h8000_0000);
		cmd(dispatch_pkg::CMD_CALLX_IPREL, 32'h1000_0004);
		reg_is(dispatch_pkg::OFF_IP, 32'h9000_0004);
		flags(2'h0);
		$display("local test done");
	endtask
	// Slow memory; user to supervisor and back through two returns
	task automatic t_table;
		stall <= 4'h3;
		bus(1'b1, dispatch_pkg::OFF_STACK_TOP, 32'h0000_1104);
		cmd(dispatch_pkg::CMD_CALLS, 32'h0);
		reg_is(dispatch_pkg::OFF_IP, 32'h0000_4000);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_1110);
		flags(2'h0);
		cmd(dispatch_pkg::CMD_CALLS, 32'h1);
		reg_is(dispatch_pkg::OFF_IP, 32'h0000_5000);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_2010);
		reg_is(dispatch_pkg::OFF_PFP, 32'h0000_1112);
		flags(2'h3);
		cmd(dispatch_pkg::CMD_CALLS, 32'h1);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_2050);
		reg_is(dispatch_pkg::OFF_PFP, 32'h0000_2010);
		cmd(dispatch_pkg::CMD_FAULT, 32'h0);
		reg_is(dispatch_pkg::OFF_PFP, 32'h0000_2051);
		cmd(dispatch_pkg::CMD_CALL, 32'h0);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_20D0);
		bus(1'b1, dispatch_pkg::OFF_PFP, 32'h0000_2090);
		cmd(dispatch_pkg::CMD_RET, 32'h0);
		flags(2'h3);
		bus(1'b1, dispatch_pkg::OFF_PFP, 32'h0000_101A);
		cmd(dispatch_pkg::CMD_RET, 32'h0);
		reg_is(dispatch_pkg::OFF_FP, 32'h0000_1010);
		flags(2'h0);
		// Eight frames pushed since reset, two popped by the returns
		reg_is(dispatch_pkg::OFF_DEPTH, 32'h0000_0006);
		$display("table test done");
	endtask
	task automatic t_reserved;
		logic [31:0] op [3] = '{32'h2, 32'h3, 32'h104};
		foreach (op[i]) begin
			cmd(dispatch_pkg::CMD_CALLS, op[i]);
			check(q & 32'h8, 32'h8);
			reg_is(dispatch_pkg::OFF_IP, 32'h0000_4000);
		end
		// An undefined command code reports an error as well
		cmd(3'h7, 32'h0);
		check(q & 32'h8, 32'h8);
		cmd(dispatch_pkg::CMD_CALLS, 32'h0);
		check(q & 32'h8, 32'h0);
		$display("reserved test done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_init;
		t_local;
		t_table;
		t_reserved;
		cmd(dispatch_pkg::CMD_CALLS, 32'h1);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		t_init;
		tally_and_finish;
	end
endmodule
